// File: rtl/capture_reload_timer.v
// 16-bit capture / auto-reload / baud / clock-out timer with a plain register port
`timescale 1ns/1ps
`include "capture_reload_timer_defs.vh"
module capture_reload_timer (
  input wire clk,
  input wire rst,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire count_clock_pin_in,
  output reg count_clock_pin_out,
  output reg count_clock_pin_oe,
  input wire trigger_pin,
  output reg irq,
  output reg rx_baud_tick,
  output reg tx_baud_tick
);
  reg [7:0] control;
  reg up_down_enable;
  reg clock_out_enable;
  reg double_speed_select;
  reg [7:0] count_low_byte;
  reg [7:0] count_high_byte;
  reg [7:0] capture_reload_low;
  reg [7:0] capture_reload_high;
  reg [1:0] trig_sync;
  reg trig_prev;
  reg [1:0] cnt_sync;
  reg cnt_prev;
  reg [3:0] presc;
  reg xtal_phase;
  reg next_ovf;
  reg next_ext;
  reg [15:0] next_count;
  reg [15:0] next_cap;
  reg tick;
  reg wrap;
  wire overflow_flag = control[`CRT_CTRL_OVF];
  wire external_flag = control[`CRT_CTRL_EXT];
  wire rx_clock_select = control[`CRT_CTRL_RXSEL];
  wire tx_clock_select = control[`CRT_CTRL_TXSEL];
  wire external_enable = control[`CRT_CTRL_EXEN];
  wire run_control = control[`CRT_CTRL_RUN];
  wire counter_select = control[`CRT_CTRL_CNTSEL];
  wire capture_reload_select = control[`CRT_CTRL_CAPSEL];
  wire [15:0] count = {count_high_byte, count_low_byte};
  wire [15:0] reload = {capture_reload_high, capture_reload_low};
  wire baud_mode = rx_clock_select | tx_clock_select;
  wire capture_mode = !baud_mode && capture_reload_select;
  wire reload_mode = !baud_mode && !capture_reload_select;
  wire clkout_mode = clock_out_enable && !counter_select;
  wire trig_fall = trig_prev && !trig_sync[1];
  wire cnt_fall = cnt_prev && !cnt_sync[1];
  wire updown = reload_mode && up_down_enable && !clkout_mode;
  wire [3:0] div = clkout_mode ? `CRT_DIV_CLKOUT : `CRT_DIV_TIMER;
  // the clk input stands for the crystal; standard mode halves it to form the oscillator
  wire osc_en = double_speed_select | xtal_phase;
  wire presc_done = osc_en && (presc == div - 4'h1);

  always @*
  begin
    tick = 1'b0;
    if (run_control)
    begin
      if (counter_select && !clkout_mode)
        tick = cnt_fall;
      else
        tick = presc_done;
    end
  end

  always @*
  begin
    next_ovf = overflow_flag;
    next_ext = external_flag;
    next_count = count;
    next_cap = reload;
    wrap = 1'b0;
    // software writes first so hardware events below win over a clear
    if (wr && addr == `CRT_ADDR_CTRL)
    begin
      next_ovf = wdata[`CRT_CTRL_OVF];
      next_ext = wdata[`CRT_CTRL_EXT];
    end
    if (wr && addr == `CRT_ADDR_CNT_LOW)
      next_count[7:0] = wdata;
    if (wr && addr == `CRT_ADDR_CNT_HIGH)
      next_count[15:8] = wdata;
    if (wr && addr == `CRT_ADDR_CAP_LOW)
      next_cap[7:0] = wdata;
    if (wr && addr == `CRT_ADDR_CAP_HIGH)
      next_cap[15:8] = wdata;
    if (run_control)
    begin
      if (tick)
      begin
        if (updown && !trig_sync[1])
        begin
          if (count == reload)
          begin
            next_count = `CRT_COUNT_MAX;
            next_ovf = 1'b1;
            wrap = 1'b1;
          end
          else
            next_count = count - 16'h0001;
        end
        else if (count == `CRT_COUNT_MAX)
        begin
          wrap = 1'b1;
          if (capture_mode && !clkout_mode)
            next_count = 16'h0000;
          else
            next_count = reload;
          if (!baud_mode && !clkout_mode)
            next_ovf = 1'b1;
        end
        else
          next_count = count + 16'h0001;
      end
      if (updown && wrap)
        next_ext = !external_flag;
      else if (external_enable && trig_fall && !updown && !baud_mode)
      begin
        next_ext = 1'b1;
        if (capture_mode)
          next_cap = count;
        else if (!wrap)
          next_count = reload;
      end
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      control <= `CRT_RESET_BYTE;
      up_down_enable <= 1'b0;
      clock_out_enable <= 1'b0;
      double_speed_select <= 1'b0;
      count_low_byte <= `CRT_RESET_BYTE;
      count_high_byte <= `CRT_RESET_BYTE;
      capture_reload_low <= `CRT_RESET_BYTE;
      capture_reload_high <= `CRT_RESET_BYTE;
      trig_sync <= 2'b11;
      trig_prev <= 1'b1;
      cnt_sync <= 2'b11;
      cnt_prev <= 1'b1;
      presc <= 4'h0;
      xtal_phase <= 1'b0;
      rdata <= 8'h00;
      irq <= 1'b0;
      rx_baud_tick <= 1'b0;
      tx_baud_tick <= 1'b0;
      count_clock_pin_out <= 1'b0;
      count_clock_pin_oe <= 1'b0;
    end
    else
    begin
      trig_sync <= {trig_sync[0], trigger_pin};
      trig_prev <= trig_sync[1];
      cnt_sync <= {cnt_sync[0], count_clock_pin_in};
      cnt_prev <= cnt_sync[1];
      xtal_phase <= !xtal_phase;
      if (!run_control)
        presc <= 4'h0;
      else if (presc_done)
        presc <= 4'h0;
      else if (osc_en)
        presc <= presc + 4'h1;
      if (wr && addr == `CRT_ADDR_CTRL)
        control[5:0] <= wdata[5:0];
      control[`CRT_CTRL_OVF] <= next_ovf;
      control[`CRT_CTRL_EXT] <= next_ext;
      if (wr && addr == `CRT_ADDR_MODE)
      begin
        up_down_enable <= wdata[`CRT_MODE_UPDN];
        clock_out_enable <= wdata[`CRT_MODE_CKOE];
      end
      if (wr && addr == `CRT_ADDR_CLKCTL)
        double_speed_select <= wdata[`CRT_CLKCTL_X2];
      count_low_byte <= next_count[7:0];
      count_high_byte <= next_count[15:8];
      capture_reload_low <= next_cap[7:0];
      capture_reload_high <= next_cap[15:8];
      rx_baud_tick <= wrap && rx_clock_select;
      tx_baud_tick <= wrap && tx_clock_select;
      // toggle per overflow: half period = (65536-reload) ticks at osc/2
      count_clock_pin_oe <= clock_out_enable;
      if (!clock_out_enable)
        count_clock_pin_out <= 1'b0;
      else if (wrap && clkout_mode)
        count_clock_pin_out <= !count_clock_pin_out;
      // up/down toggling of the external flag must not request an interrupt
      irq <= next_ovf | (next_ext & !updown);
      rdata <= 8'h00;
      if (rd)
      begin
        case (addr)
          `CRT_ADDR_CTRL: rdata <= control;
          `CRT_ADDR_MODE: rdata <= {6'h00, clock_out_enable, up_down_enable};
          `CRT_ADDR_CNT_LOW: rdata <= count_low_byte;
          `CRT_ADDR_CNT_HIGH: rdata <= count_high_byte;
          `CRT_ADDR_CAP_LOW: rdata <= capture_reload_low;
          `CRT_ADDR_CAP_HIGH: rdata <= capture_reload_high;
          `CRT_ADDR_CLKCTL: rdata <= {7'h00, double_speed_select};
          default: rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule // capture_reload_timer

// File: rtl/capture_reload_timer_defs.vh
// constants for the capture/reload timer
`ifndef CAPTURE_RELOAD_TIMER_DEFS_VH
`define CAPTURE_RELOAD_TIMER_DEFS_VH
`define CRT_ADDR_CTRL 4'h0
`define CRT_ADDR_MODE 4'h1
`define CRT_ADDR_CNT_LOW 4'h2
`define CRT_ADDR_CNT_HIGH 4'h3
`define CRT_ADDR_CAP_LOW 4'h4
`define CRT_ADDR_CAP_HIGH 4'h5
`define CRT_ADDR_CLKCTL 4'h6
`define CRT_CTRL_OVF 7
`define CRT_CTRL_EXT 6
`define CRT_CTRL_RXSEL 5
`define CRT_CTRL_TXSEL 4
`define CRT_CTRL_EXEN 3
`define CRT_CTRL_RUN 2
`define CRT_CTRL_CNTSEL 1
`define CRT_CTRL_CAPSEL 0
`define CRT_MODE_UPDN 0
`define CRT_MODE_CKOE 1
`define CRT_CLKCTL_X2 0
`define CRT_RESET_BYTE 8'h00
`define CRT_DIV_TIMER 4'h6
`define CRT_DIV_CLKOUT 4'h2
`define CRT_COUNT_MAX 16'hFFFF
`endif

// File: tb/capture_reload_timer_monitor.sv
// port-level checks for the capture/reload timer
`timescale 1ns/1ps
module crt_monitor (
  input wire clk,
  input wire rst,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire count_clock_pin_out,
  input wire count_clock_pin_oe,
  input wire irq,
  input wire rx_baud_tick,
  input wire tx_baud_tick
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rx_pulse; rx_baud_tick |=> !rx_baud_tick; endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx tick too long");
  property p_tx_pulse; tx_baud_tick |=> !tx_baud_tick; endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("tx tick too long");
  property p_oe_on; wr && addr == 4'h1 && wdata[1] |-> ##2 count_clock_pin_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("pin not driven");
  property p_oe_off; wr && addr == 4'h1 && !wdata[1] |-> ##2 !count_clock_pin_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin still driven");
  property p_out_quiet; !count_clock_pin_oe [*2] |-> !count_clock_pin_out; endproperty
  a_out_quiet: assert property (p_out_quiet) else $error("clock out while off");
  // irq can only come from a flag, and baud mode never sets one
  property p_baud_noovf; rx_baud_tick && !irq && !wr |=> !irq; endproperty
  a_baud_noovf: assert property (p_baud_noovf) else $error("flag set in baud");
  property p_irq_hold; irq && !wr && !$past(wr) |=> irq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
  property p_irq_ovf; (rd && addr == 4'h0) ##1 rdata[7] |-> ##[0:1] irq; endproperty
  a_irq_ovf: assert property (p_irq_ovf) else $error("overflow without irq");
  c_baud: cover property (rx_baud_tick);
  c_clkout: cover property ($rose(count_clock_pin_out));
  c_irq: cover property ($rose(irq));
endmodule // crt_monitor
bind capture_reload_timer crt_monitor crt_monitor_inst (.clk(clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .count_clock_pin_out(count_clock_pin_out),
  .count_clock_pin_oe(count_clock_pin_oe), .irq(irq), .rx_baud_tick(rx_baud_tick),
  .tx_baud_tick(tx_baud_tick));

// File: tb/capture_reload_timer_tb_top.sv
// self-checking bench for the capture/reload timer
`timescale 1ns/1ps
module capture_reload_timer_tb_top;
  reg clk = 0, rst = 1, wr = 0, rd = 0, cnt_drv = 1, trig_drv = 1;
  reg [3:0] addr = 4'h0;
  reg [7:0] wdata = 8'h00;
  wire [7:0] rdata;
  wire pin_in, pin_out, pin_oe, trig, irq, rxt, txt;
  integer fail_count = 0, cmp_count = 0, cyc = 0, k, nr, nt;
  initial forever #2.5 clk = ~clk;
  capture_reload_timer capture_reload_timer_inst (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .count_clock_pin_in(pin_in),
    .count_clock_pin_out(pin_out), .count_clock_pin_oe(pin_oe), .trigger_pin(trig),
    .irq(irq), .rx_baud_tick(rxt), .tx_baud_tick(txt));
  timer_pin_model timer_pin_model_inst (.cnt_drv(cnt_drv), .trig_drv(trig_drv),
    .count_clock_pin_out(pin_out), .count_clock_pin_oe(pin_oe),
    .count_clock_pin_in(pin_in), .trigger_pin(trig));
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input [3:0] n, input [7:0] s, input [7:0] e);
    cmp_count = cmp_count + 1;
    if (s !== e)
    begin
      fail_count = fail_count + 1;
      $display("ERROR item %h expected %h seen %h", n, e, s);
    end
  endtask
  task w(input [3:0] a, input [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task r(input [3:0] a, input [7:0] m, input [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk(a, rdata & m, e);
  endtask
  // hang guard, tests need well under a thousand cycles
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      fail_count = fail_count + 1;
      final_report;
    end
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 0;
    r(4'h0, 8'hFF, 8'h00);
    r(4'h7, 8'hFF, 8'h00);
    w(4'h1, 8'hFF);
    r(4'h1, 8'hFF, 8'h03);
    w(4'h1, 8'h00);
    w(4'h6, 8'hFF);
    r(4'h6, 8'hFF, 8'h01);
    w(4'h4, 8'h34);
    w(4'h5, 8'h12);
    w(4'h2, 8'hFE);
    w(4'h3, 8'hFF);
    w(4'h0, 8'h04);
    repeat (30) @(posedge clk);
    r(4'h3, 8'hFF, 8'h12);
    r(4'h0, 8'h80, 8'h80);
    w(4'h0, 8'h00);
    r(4'h0, 8'hFF, 8'h00);
    w(4'h3, 8'h55);
    w(4'h0, 8'h0D);
    trig_drv <= 0;
    repeat (8) @(posedge clk);
    r(4'h5, 8'hFF, 8'h55);
    r(4'h0, 8'h40, 8'h40);
    trig_drv <= 1;
    w(4'h0, 8'h00);
    w(4'h2, 8'h00);
    w(4'h0, 8'h06);
    repeat (5)
    begin
      repeat (4) @(posedge clk) cnt_drv <= 0;
      repeat (4) @(posedge clk) cnt_drv <= 1;
    end
    r(4'h2, 8'hFF, 8'h05);
    w(4'h0, 8'h00);
    w(4'h1, 8'h01);
    w(4'h4, 8'h10);
    w(4'h5, 8'h00);
    w(4'h3, 8'h00);
    w(4'h2, 8'h11);
    trig_drv <= 0;
    w(4'h0, 8'h04);
    repeat (30) @(posedge clk);
    r(4'h3, 8'hFF, 8'hFF);
    r(4'h0, 8'hC0, 8'hC0);
    w(4'h0, 8'h40);
    repeat (3) @(posedge clk);
    #1 chk(4'hA, irq, 8'h00);
    trig_drv <= 1;
    w(4'h0, 8'h00);
    w(4'h1, 8'h02);
    w(4'h4, 8'hFE);
    w(4'h5, 8'hFF);
    w(4'h2, 8'hFE);
    w(4'h3, 8'hFF);
    w(4'h0, 8'h04);
    k = 0;
    while (pin_out !== 1'b1 && k < 40) @(posedge clk) #1 k = k + 1;
    k = 0;
    while (pin_out === 1'b1 && k < 40) @(posedge clk) #1 k = k + 1;
    chk(4'hB, k, 8'h04);
    chk(4'hC, pin_oe, 8'h01);
    r(4'h0, 8'h80, 8'h00);
    w(4'h0, 8'h00);
    w(4'h1, 8'h00);
    w(4'h4, 8'hFF);
    w(4'h0, 8'h34);
    repeat (20) @(posedge clk);
    nr = 0;
    nt = 0;
    repeat (60)
    begin
      @(posedge clk) #1 nr = nr + rxt;
      nt = nt + txt;
    end
    chk(4'hD, nr, 8'h0A);
    chk(4'hE, nt, 8'h0A);
    r(4'h0, 8'h80, 8'h00);
    // capture mode without external enable: plain rollover to zero
    w(4'h0, 8'h00);
    w(4'h2, 8'hFE);
    w(4'h3, 8'hFF);
    w(4'h0, 8'h05);
    repeat (30) @(posedge clk);
    r(4'h3, 8'hFF, 8'h00);
    r(4'h0, 8'h80, 8'h80);
    // reload mode: trigger edge forces the reload
    w(4'h0, 8'h00);
    w(4'h4, 8'h00);
    w(4'h5, 8'hAB);
    w(4'h3, 8'h00);
    w(4'h0, 8'h0C);
    trig_drv <= 0;
    repeat (8) @(posedge clk);
    r(4'h3, 8'hFF, 8'hAB);
    r(4'h0, 8'h40, 8'h40);
    trig_drv <= 1;
    // up/down with trigger high: overflow reloads and toggles the external flag
    w(4'h0, 8'h00);
    w(4'h1, 8'h01);
    w(4'h5, 8'h20);
    w(4'h2, 8'hFF);
    w(4'h3, 8'hFF);
    w(4'h0, 8'h04);
    repeat (12) @(posedge clk);
    r(4'h3, 8'hFF, 8'h20);
    r(4'h0, 8'hC0, 8'hC0);
    final_report;
  end
endmodule // capture_reload_timer_tb_top

// File: tb/timer_pin_model.sv
// far side: shared count/clock-out pin and trigger pin
`timescale 1ns/1ps
module timer_pin_model (
  input wire cnt_drv,
  input wire trig_drv,
  input wire count_clock_pin_out,
  input wire count_clock_pin_oe,
  output wire count_clock_pin_in,
  output wire trigger_pin
);
  // the outside source yields the pin while the timer drives it
  assign count_clock_pin_in = count_clock_pin_oe ? count_clock_pin_out : cnt_drv;
  assign trigger_pin = trig_drv;
endmodule // timer_pin_model
